// [logic/rss_consts.svh]
// opcode, field and width constants for the rotate/sleep/subtract executor
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH
`define RSS_OP_RLF_HI   6'h0D
`define RSS_OP_SUBF_HI  6'h02
`define RSS_OP_SUBL_HI  5'h1E
`define RSS_OP_SLEEP    14'h0063
`define RSS_DEST_BIT    7
`define RSS_GUARD_W     8
`define RSS_PRESC_W     8
`define RSS_GUARD_ZERO  8'h00
`define RSS_PRESC_ZERO  8'h00
`endif

// [logic/rss_exec.sv]
// executor for rotate-left, both subtract forms and power-down entry
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "rss_consts.svh"
// Operation
// - rotate addressed register left through carry, old carry into bit 0
// - rotate result goes to accumulator if target bit 0, else to register
// - power-down opcode clears sleep flag, sets watchdog expiry flag
// - power-down clears guard counter and its prescaler
// - after power-down, sleep with oscillator halted until wake-up
// - literal minus accumulator into accumulator, updates carry, nibble and zero
// - register minus accumulator, updates carry, nibble borrow and zero
// - register subtract result to accumulator if target bit 0, else register
// - carry set when difference non-negative, cleared when negative
module rss_exec
  import rss_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  input wire logic [7:0] file_rdata,
  input wire logic wake_event,
  input wire logic guard_tick,
  output logic [6:0] file_addr,
  output logic file_we,
  output logic [7:0] file_wdata,
  output logic [7:0] acc,
  output logic ripple_out_bit,
  output logic nibble_borrow_flag,
  output logic result_null_flag,
  output logic watchdog_expiry_flag,
  output logic sleep_entry_flag,
  output logic [`RSS_GUARD_W-1:0] guard_counter,
  output logic [`RSS_PRESC_W-1:0] guard_prescaler,
  output logic osc_run,
  output logic instr_ready
);
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  rss_op_t op;
  logic dest_reg;
  logic [7:0] sub_a;
  logic [7:0] diff;
  logic nb;
  logic nnb;
  logic zr;
  rss_state_t st_q, st_d;

  assign instr_ready = (st_q == RSS_ST_RUN);
  assign file_addr = instr_word[6:0];
  assign dest_reg = instr_word[`RSS_DEST_BIT];

  always_comb begin
    op = RSS_OP_NONE;
    if (instr_valid && st_q == RSS_ST_RUN) begin
      if (instr_word == `RSS_OP_SLEEP) begin
        op = RSS_OP_SLP;
      end else if (instr_word[13:8] == `RSS_OP_RLF_HI) begin
        op = RSS_OP_ROT;
      end else if (instr_word[13:8] == `RSS_OP_SUBF_HI) begin
        op = RSS_OP_SUBF;
      end else if (instr_word[13:9] == `RSS_OP_SUBL_HI) begin
        op = RSS_OP_SUBL;
      end
    end
    sub_a = (op == RSS_OP_SUBL) ? instr_word[7:0] : file_rdata;
  end

  rss_sub8 u_sub (
    .a(sub_a),
    .b(acc),
    .diff(diff),
    .no_borrow(nb),
    .nib_no_borrow(nnb),
    .zero(zr)
  );

  // ------------------------------------------------------------
  // execute
  // ------------------------------------------------------------
  logic [7:0] acc_q, acc_d, wdata_q, wdata_d;
  logic we_q, we_d;
  logic c_q, c_d, dc_q, dc_d, z_q, z_d, to_q, to_d, pd_q, pd_d;
  logic [`RSS_GUARD_W-1:0] gc_q, gc_d;
  logic [`RSS_PRESC_W-1:0] ps_q, ps_d;
  logic [7:0] rot;

  always_comb begin
    acc_d = acc_q;
    wdata_d = wdata_q;
    we_d = 1'b0;
    c_d = c_q;
    dc_d = dc_q;
    z_d = z_q;
    to_d = to_q;
    pd_d = pd_q;
    rot = {file_rdata[6:0], c_q};
    unique case (op)
      RSS_OP_ROT: begin
        c_d = file_rdata[7];
        if (dest_reg) begin
          we_d = 1'b1;
          wdata_d = rot;
        end else begin
          acc_d = rot;
        end
      end
      RSS_OP_SUBF: begin
        c_d = nb;
        dc_d = nnb;
        z_d = zr;
        if (dest_reg) begin
          we_d = 1'b1;
          wdata_d = diff;
        end else begin
          acc_d = diff;
        end
      end
      RSS_OP_SUBL: begin
        acc_d = diff;
        c_d = nb;
        dc_d = nnb;
        z_d = zr;
      end
      RSS_OP_SLP: begin
        pd_d = 1'b0;
        to_d = 1'b1;
      end
      RSS_OP_NONE: begin
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      acc_q <= 8'h00;
      wdata_q <= 8'h00;
      we_q <= 1'b0;
      c_q <= 1'b0;
      dc_q <= 1'b0;
      z_q <= 1'b0;
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end else begin
      acc_q <= acc_d;
      wdata_q <= wdata_d;
      we_q <= we_d;
      c_q <= c_d;
      dc_q <= dc_d;
      z_q <= z_d;
      to_q <= to_d;
      pd_q <= pd_d;
    end
  end

  // ------------------------------------------------------------
  // power state
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      RSS_ST_RUN: begin
        if (op == RSS_OP_SLP) begin
          st_d = RSS_ST_SLEEP;
        end
      end
      RSS_ST_SLEEP: begin
        if (wake_event) begin
          st_d = RSS_ST_RUN;
        end
      end
      default: begin
        st_d = RSS_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= RSS_ST_RUN;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------
  // guard counter and prescaler
  // ------------------------------------------------------------
  // power-down clear wins over a tick on the same edge
  always_comb begin
    {gc_d, ps_d} = {gc_q, ps_q};
    if (op == RSS_OP_SLP) begin
      gc_d = `RSS_GUARD_ZERO;
      ps_d = `RSS_PRESC_ZERO;
    end else if (guard_tick) begin
      {gc_d, ps_d} = {gc_q, ps_q} + 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      gc_q <= `RSS_GUARD_ZERO;
      ps_q <= `RSS_PRESC_ZERO;
    end else begin
      gc_q <= gc_d;
      ps_q <= ps_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign acc = acc_q;
  assign file_we = we_q;
  assign file_wdata = wdata_q;
  assign ripple_out_bit = c_q;
  assign nibble_borrow_flag = dc_q;
  assign result_null_flag = z_q;
  assign watchdog_expiry_flag = to_q;
  assign sleep_entry_flag = pd_q;
  assign guard_counter = gc_q;
  assign guard_prescaler = ps_q;
  assign osc_run = (st_q == RSS_ST_RUN);
endmodule

// [logic/rss_pkg.sv]
// types for the rotate/sleep/subtract executor
package rss_pkg;
  typedef enum logic [4:0] {
    RSS_OP_NONE  = 5'b00001,
    RSS_OP_ROT   = 5'b00010,
    RSS_OP_SUBF  = 5'b00100,
    RSS_OP_SUBL  = 5'b01000,
    RSS_OP_SLP   = 5'b10000
  } rss_op_t;
  typedef enum logic [1:0] {
    RSS_ST_RUN   = 2'b01,
    RSS_ST_SLEEP = 2'b10
  } rss_state_t;
endpackage

// [logic/rss_sub8.sv]
// 8-bit a minus b with carry-as-no-borrow, nibble borrow and zero flags
`timescale 1ns/100ps
module rss_sub8 (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  output logic [7:0] diff,
  output logic no_borrow,
  output logic nib_no_borrow,
  output logic zero
);
  logic [8:0] full;
  logic [4:0] low;
  always_comb begin
    full = {1'b0, a} + {1'b0, ~b} + 9'h001;
    low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
    diff = full[7:0];
    no_borrow = full[8];
    nib_no_borrow = low[4];
    zero = (full[7:0] == 8'h00);
  end
endmodule

// [test/rotate_sleep_subtract_exec_test.sv]
// self-checking bench for the rotate/sleep/subtract executor
`timescale 1ns/100ps
module rotate_sleep_subtract_exec_test;
  logic mclk = 0, reset_n = 0, instr_valid = 0, wake_event = 0, guard_tick = 0;
  logic [13:0] instr_word = 14'h0000;
  logic [7:0] file_rdata = 8'h00, acc, file_wdata, guard_counter, guard_prescaler;
  logic [6:0] file_addr;
  logic file_we, ripple_out_bit, nibble_borrow_flag, result_null_flag;
  logic watchdog_expiry_flag, sleep_entry_flag, osc_run, instr_ready;
  int n_fail = 0, comparisons = 0;
  // word, read data, result, {nibble, carry, zero}
  logic [35:0] rows [9] = '{36'h3C02_00_02_6, 36'h3C02_00_00_7, 36'h0D25_E6_CD_7,
    36'h3D01_00_34_0, 36'h0D25_E6_CC_2, 36'h0225_03_37_0, 36'h0225_37_00_7,
    36'h0DA5_81_03_7, 36'h02A5_05_05_6};
  rss_exec dut (.*);
  always #5 mclk = ~mclk;
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #5000;
    n_fail++;
    summarize();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    #1;
    chk({sleep_entry_flag, watchdog_expiry_flag, osc_run, instr_ready}, 8'h0F);
    $display("reset done");
    foreach (rows[i]) begin
      @(posedge mclk);
      instr_valid <= 1'b1;
      instr_word <= rows[i][33:20];
      file_rdata <= rows[i][19:12];
      @(posedge mclk);
      instr_valid <= 1'b0;
      #1;
      chk(instr_word[7] ? file_wdata : acc, rows[i][11:4]);
      chk(ripple_out_bit, rows[i][1]);
      chk(result_null_flag, rows[i][0]);
      chk(nibble_borrow_flag, rows[i][2]);
      chk(file_addr, rows[i][26:20]);
      chk(file_we, instr_word[7]);
    end
    $display("rows done");
    // tick lands on the sleep edge: clear must win
    @(posedge mclk) guard_tick <= 1'b1;
    @(posedge mclk) begin
      instr_valid <= 1'b1;
      instr_word <= 14'h0063;
    end
    @(posedge mclk) begin
      guard_tick <= 1'b0;
      instr_word <= 14'h3CFF;
    end
    @(posedge mclk) begin
      instr_valid <= 1'b0;
      wake_event <= 1'b1;
    end
    #1;
    chk(guard_counter | guard_prescaler, 8'h00);
    chk({sleep_entry_flag, watchdog_expiry_flag, osc_run, instr_ready}, 8'h04);
    chk(acc, 8'h00);
    @(posedge mclk) wake_event <= 1'b0;
    #1 chk(instr_ready, 1'b1);
    $display("sleep done");
    // one tick and a literal subtract, then a reset in mid-run
    @(posedge mclk) begin
      guard_tick <= 1'b1;
      instr_valid <= 1'b1;
      instr_word <= 14'h3C80;
    end
    @(posedge mclk) begin
      guard_tick <= 1'b0;
      instr_valid <= 1'b0;
    end
    #1;
    chk(guard_prescaler, 8'h01);
    chk(acc, 8'h80);
    @(posedge mclk) reset_n <= 1'b0;
    #1;
    chk(acc, 8'h00);
    chk({sleep_entry_flag, watchdog_expiry_flag, osc_run, instr_ready, ripple_out_bit,
      nibble_borrow_flag, result_null_flag}, 8'h78);
    chk(guard_counter | guard_prescaler, 8'h00);
    @(posedge mclk) begin
      reset_n <= 1'b1;
      instr_valid <= 1'b1;
      instr_word <= 14'h3C02;
    end
    @(posedge mclk) instr_valid <= 1'b0;
    #1 chk(acc, 8'h02);
    $display("reset test done");
    summarize();
  end
endmodule

// [test/rss_exec_chk.sv]
// assertions for the rotate/sleep/subtract executor
`timescale 1ns/100ps
module rss_exec_chk (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  input wire logic [7:0] file_rdata,
  input wire logic file_we,
  input wire logic [7:0] file_wdata,
  input wire logic [7:0] acc,
  input wire logic ripple_out_bit,
  input wire logic nibble_borrow_flag,
  input wire logic result_null_flag,
  input wire logic watchdog_expiry_flag,
  input wire logic sleep_entry_flag,
  input wire logic [7:0] guard_counter,
  input wire logic [7:0] guard_prescaler,
  input wire logic osc_run,
  input wire logic instr_ready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire v = instr_valid && instr_ready;
  wire rot = v && instr_word[13:8] == 6'h0D;
  wire sbf = v && instr_word[13:8] == 6'h02;
  wire sbl = v && instr_word[13:9] == 5'h1E;
  wire slp = v && instr_word == 14'h0063;
  wire [8:0] df = {1'h0, file_rdata} - {1'h0, acc};
  wire [8:0] dl = {1'h0, instr_word[7:0]} - {1'h0, acc};
  wire [7:0] rl = {file_rdata[6:0], ripple_out_bit};
  wire nl = instr_word[3:0] >= acc[3:0];
  wire nf = file_rdata[3:0] >= acc[3:0];
  a_rot_acc:
    assert property (rot && !instr_word[7] |=> acc == $past(rl) && !file_we) else $error("rot");
  a_rot_carry:
    assert property (rot |=> ripple_out_bit == $past(file_rdata[7]) && $stable(result_null_flag)
      && $stable(nibble_borrow_flag)) else $error("rot flags");
  a_rot_file:
    assert property (rot && instr_word[7] |=> file_we && file_wdata == $past(rl) && $stable(acc))
    else $error("rot dest");
  a_subl_res:
    assert property (sbl |=> acc == $past(dl[7:0]) && ripple_out_bit != $past(dl[8]))
    else $error("subl");
  a_subf_acc:
    assert property (sbf && !instr_word[7] |=> acc == $past(df[7:0]) && result_null_flag == (acc == 8'h00))
    else $error("subf");
  a_subf_file:
    assert property (sbf && instr_word[7] |=> file_we && file_wdata == $past(df[7:0])
      && ripple_out_bit != $past(df[8])) else $error("subf dest");
  a_sleep_flags:
    assert property (slp |=> !sleep_entry_flag && watchdog_expiry_flag && guard_counter == 8'h00
      && guard_prescaler == 8'h00) else $error("sleep flags");
  a_sleep_halt:
    assert property (slp |=> !osc_run && !instr_ready) else $error("sleep halt");
  a_subl_nibble:
    assert property (sbl |=> nibble_borrow_flag == $past(nl)) else $error("subl nibble");
  a_subf_nibble:
    assert property (sbf |=> nibble_borrow_flag == $past(nf)) else $error("subf nibble");
  a_sleep_refuse:
    assert property (!instr_ready |=> $stable(acc) && !file_we) else $error("sleep refuse");
  cover property (rot && instr_word[7]);
  cover property (sbl);
  cover property (slp);
endmodule
bind rss_exec rss_exec_chk chk (.*);
